// ===== core/qdw_core.sv
// Device-side interpreter of the queued DMA write command with APB registers.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// Function
// - Code CCh runs as queued DMA write.
// - Length from transfer_length, zero means 256.
// - Tag from bits 7:3, any 0..31.
// - Select bit 6 chooses LBA or CHS.
// - Address assembled from four registers.
// - Transfer now or after SERVICE.
// - Data start: tag, REL zero, I/O zero.
// - Data start: C/D zero.
// - Data start status; SERV if other ready.
// - Tag not applicable without queuing or overlap; completion and error still show it with queuing on alone.
// - Release only before any data moved.
// - Release reports tag, or zeros.
// - Release sets REL, clears I/O, C/D.
// - Release: BSY zero, DRDY one, rest zero.
// - SERV follows readiness after a release.
// - Ready for service raises SERV only.
// - SERVICE presents matching output content.
// - Good completion shows error flags zero.
// - DEV bit always shows selected device.
// - Completion: REL 0, I/O, C/D 1.
// - No release once data has started.
// - Unrecoverable error aborts whole queue.
module qdw_core
  import qdw_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Back end readiness and data phase events.
  input wire logic tag_ready,
  input wire logic [4:0] tag_ready_id,
  input wire logic sector_done,
  input wire logic xfer_error,
  input wire logic [7:0] xfer_error_code,
  // Current data phase towards the back end.
  output logic xfer_active,
  output logic [4:0] xfer_tag,
  output logic [27:0] xfer_addr,
  output logic xfer_lba_mode,
  output logic [8:0] xfer_remaining
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    seq_state_t state;
    logic [7:0] feat;
    logic [7:0] sc;
    logic [7:0] sn;
    logic [7:0] cl;
    logic [7:0] ch;
    logic [7:0] dh;
    logic [7:0] err;
    logic bsy;
    logic drq;
    logic errb;
    logic [NUM_TAGS-1:0] ready;
    logic [NUM_TAGS-1:0] outst;
    logic [4:0] tag;
    logic [8:0] remain;
    logic [27:0] addr;
    logic lba;
    logic [2:0] ctrl;
    logic ack;
    logic slverr;
    logic [31:0] rdata;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // Decodes an offset into a one-hot register select; bit 12 is a miss.
  function automatic logic [12:0] decode(input logic [7:0] a);
    logic [12:0] d;
    d = 13'h0000;
    case (a)
      OFF_TRANSFER_LENGTH: d[0] = 1'b1;
      OFF_TAG_AND_REASON: d[1] = 1'b1;
      OFF_START_ADDR_LOW: d[2] = 1'b1;
      OFF_START_ADDR_MID: d[3] = 1'b1;
      OFF_START_ADDR_HIGH: d[4] = 1'b1;
      OFF_DEVICE_SELECT_ADDR_TOP: d[5] = 1'b1;
      OFF_COMMAND_CODE: d[6] = 1'b1;
      OFF_ERROR_FLAGS: d[7] = 1'b1;
      OFF_DEVICE_STATUS: d[8] = 1'b1;
      OFF_QUEUE_CONTROL: d[9] = 1'b1;
      OFF_OUTSTANDING_TAGS: d[10] = 1'b1;
      OFF_READY_TAGS: d[11] = 1'b1;
      default: d[12] = 1'b1;
    endcase
    return d;
  endfunction : decode

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Links to the tag picker and the command store.
  logic pick_any;
  logic [4:0] pick_tag;
  logic [ENTRY_W-1:0] entry;
  logic mem_we;
  logic [ENTRY_W-1:0] mem_wdata;
  logic [4:0] mem_wtag;

  // Bus decode.
  logic [12:0] sel;
  logic [12:0] wsel;
  logic wr;

  // Views of the tag, reason and status fields.
  logic tag_valid;
  logic [4:0] rep_tag;
  logic [4:0] new_tag;
  logic [4:0] done_tag;
  logic [7:0] status;

  // Lowest ready tag wins, so the service order is fixed and repeatable.
  qdw_tag_picker u_picker (
    .ready(r.ready),
    .any(pick_any),
    .tag(pick_tag)
  );

  // Entry read data lag the tag by one cycle, which the LOAD state absorbs.
  qdw_cmd_store u_store (
    .pclk(pclk),
    .wr_en(mem_we),
    .wr_tag(mem_wtag),
    .wr_data(mem_wdata),
    .rd_tag(pick_tag),
    .rd_data(entry)
  );

  // ****************************************************************
  // Tag and status views.
  // ****************************************************************
  // The tag is only meaningful with queuing and overlap both on.
  assign tag_valid = r.ctrl[CTRL_QUEUING] & r.ctrl[CTRL_OVERLAP];
  assign rep_tag = tag_valid ? r.tag : 5'h00;
  assign new_tag = r.ctrl[CTRL_QUEUING] ? r.sc[TAG_MSB:TAG_LSB] : 5'h00;
  // Completion and error report the tag whenever queuing is on, overlap or not.
  assign done_tag = r.ctrl[CTRL_QUEUING] ? r.tag : 5'h00;

  // SERV is a live view of the ready bitmap, so raising it touches nothing else.
  assign status = {r.bsy, 1'b1, 1'b0, |r.ready, r.drq, 2'b00, r.errb};

  // Writes land only at the access edge that also carries pready.
  assign sel = decode(paddr);
  assign wsel = sel & {13{wr}};
  assign wr = psel & penable & r.ack & pwrite;

  // A new queued command is kept per tag so a later SERVICE can resume it.
  assign mem_wtag = new_tag;
  assign mem_wdata = {r.dh[SEL_LBA_BIT],
                      (r.feat == 8'h00) ? FULL_LENGTH : {1'b0, r.feat},
                      r.dh[3:0], r.ch, r.cl, r.sn};
  // Only an idle device takes a new queued command.
  assign mem_we = wsel[6] & (pwdata[7:0] == CODE_QUEUED_DMA_WRITE)
                  & ~r.bsy & (r.state == ST_IDLE);

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // One combinational pass computes the whole next state.
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.slverr = 1'b0;

    // Setup phase: latch read data so the access phase answers at once.
    if (psel & ~penable) begin
      next_r.ack = 1'b1;
      next_r.slverr = sel[12];
      next_r.rdata = 32'h0000_0000;
      // Write-only registers and the command code read back as zero.
      case (1'b1)
        sel[1]: next_r.rdata[7:0] = r.sc;
        sel[2]: next_r.rdata[7:0] = r.sn;
        sel[3]: next_r.rdata[7:0] = r.cl;
        sel[4]: next_r.rdata[7:0] = r.ch;
        sel[5]: next_r.rdata[7:0] = r.dh;
        sel[7]: next_r.rdata[7:0] = r.err;
        sel[8]: next_r.rdata[7:0] = status;
        sel[9]: next_r.rdata[2:0] = r.ctrl;
        sel[10]: next_r.rdata = r.outst;
        sel[11]: next_r.rdata = r.ready;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    // Task file writes are ignored while the device owns the registers.
    if (~r.bsy & (r.state == ST_IDLE)) begin
      if (wsel[0]) next_r.feat = pwdata[7:0];
      if (wsel[1]) next_r.sc = pwdata[7:0];
      if (wsel[2]) next_r.sn = pwdata[7:0];
      if (wsel[3]) next_r.cl = pwdata[7:0];
      if (wsel[4]) next_r.ch = pwdata[7:0];
      if (wsel[5]) next_r.dh = pwdata[7:0];
      if (wsel[9]) next_r.ctrl = pwdata[2:0];
    end

    case (r.state)
      ST_IDLE: begin
        if (mem_we) begin
          // Accept a queued write; release now or move data at once.
          next_r.tag = new_tag;
          next_r.outst[new_tag] = 1'b1;
          next_r.err = ERR_NONE;
          next_r.errb = 1'b0;
          next_r.drq = 1'b0;
          next_r.bsy = 1'b0;
          if (r.ctrl[CTRL_RELEASE] & tag_valid) begin
            // Released: no data moves until the host sends SERVICE.
            next_r.sc = {tag_valid ? new_tag : 5'h00, 3'b100};
          end else begin
            // Data start content stands from the first cycle of the phase.
            next_r.drq = 1'b1;
            next_r.sc = {tag_valid ? new_tag : 5'h00, 3'b000};
            next_r.state = ST_XFER;
            next_r.remain = mem_wdata[36:28];
            next_r.addr = mem_wdata[27:0];
            next_r.lba = r.dh[SEL_LBA_BIT];
          end
        end else if (wsel[6] & ~r.bsy) begin
          if ((pwdata[7:0] == CODE_SERVICE) & pick_any) begin
            // Resume the lowest ready tag; its entry arrives next cycle.
            next_r.tag = pick_tag;
            next_r.ready[pick_tag] = 1'b0;
            next_r.bsy = 1'b1;
            next_r.state = ST_LOAD;
          end else begin
            // Unknown code, or SERVICE with nothing to serve.
            next_r.err = ERR_ABORTED;
            next_r.errb = 1'b1;
            next_r.drq = 1'b0;
          end
        end
      end
      ST_LOAD: begin
        // Resumed command: data start content goes up with the stored entry.
        next_r.drq = 1'b1;
        next_r.sc = {rep_tag, 3'b000};
        next_r.lba = entry[37];
        next_r.remain = entry[36:28];
        next_r.addr = entry[27:0];
        next_r.bsy = 1'b0;
        next_r.err = ERR_NONE;
        next_r.errb = 1'b0;
        next_r.state = ST_XFER;
      end
      ST_XFER: begin
        // Data phase owns the bus until the last sector or an error.
        next_r.sc = {rep_tag, 3'b000};
        next_r.bsy = 1'b0;
        next_r.drq = 1'b1;
        next_r.errb = 1'b0;
        // An error outranks a sector event in the same cycle.
        if (xfer_error) begin
          // Report where it failed and drop every queued command.
          next_r.err = xfer_error_code;
          next_r.errb = 1'b1;
          next_r.drq = 1'b0;
          next_r.sn = r.addr[7:0];
          next_r.cl = r.addr[15:8];
          next_r.ch = r.addr[23:16];
          next_r.dh[3:0] = r.addr[27:24];
          next_r.sc = {done_tag, 3'b011};
          next_r.outst = {NUM_TAGS{1'b0}};
          next_r.ready = {NUM_TAGS{1'b0}};
          next_r.state = ST_IDLE;
        end else if (sector_done) begin
          // Count and, in LBA mode only, address step once per sector.
          next_r.remain = r.remain - 9'h001;
          if (r.lba) next_r.addr = r.addr + 28'h000_0001;
          if (r.remain == 9'h001) begin
            next_r.err = ERR_NONE;
            next_r.drq = 1'b0;
            // Completion shows the tag even with overlap off.
            next_r.sc = {done_tag, 3'b011};
            next_r.outst[r.tag] = 1'b0;
            next_r.state = ST_IDLE;
          end
        end
      end
      // An unused state code falls back to idle.
      default: next_r.state = ST_IDLE;
    endcase

    // Readiness is applied last so a set beats a clear in the same cycle, unless that cycle drops the tag from outstanding.
    if (tag_ready & next_r.outst[tag_ready_id]) begin
      next_r.ready[tag_ready_id] = 1'b1;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // The whole state is one register; named reset fields keep the intent visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.feat <= RST_TASK_REG;
      r.sc <= RST_TASK_REG;
      r.ctrl <= RST_CTRL;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // APB answer: ready in the first access cycle, no wait states.
  assign pready = psel & penable & r.ack;
  assign pslverr = pready & r.slverr;
  assign prdata = r.rdata;

  // Data phase view for the back end, all straight from registers.
  assign xfer_active = (r.state == ST_XFER);
  assign xfer_tag = r.tag;
  assign xfer_addr = r.addr;
  assign xfer_lba_mode = r.lba;
  assign xfer_remaining = r.remain;

endmodule : qdw_core

// ===== core/qdw_pkg.sv
// Shared constants and types for the queued DMA write command block.
package qdw_pkg;

  // ****************************************************************
  // Register byte offsets on the APB bus.
  // ****************************************************************
  localparam logic [7:0] OFF_TRANSFER_LENGTH = 8'h00;
  localparam logic [7:0] OFF_TAG_AND_REASON = 8'h04;
  localparam logic [7:0] OFF_START_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_START_ADDR_MID = 8'h0C;
  localparam logic [7:0] OFF_START_ADDR_HIGH = 8'h10;
  localparam logic [7:0] OFF_DEVICE_SELECT_ADDR_TOP = 8'h14;
  localparam logic [7:0] OFF_COMMAND_CODE = 8'h18;
  localparam logic [7:0] OFF_ERROR_FLAGS = 8'h1C;
  localparam logic [7:0] OFF_DEVICE_STATUS = 8'h20;
  localparam logic [7:0] OFF_QUEUE_CONTROL = 8'h24;
  localparam logic [7:0] OFF_OUTSTANDING_TAGS = 8'h28;
  localparam logic [7:0] OFF_READY_TAGS = 8'h2C;

  // ****************************************************************
  // Command codes and error values.
  // ****************************************************************
  localparam logic [7:0] CODE_QUEUED_DMA_WRITE = 8'hCC;
  localparam logic [7:0] CODE_SERVICE = 8'hA2;
  localparam logic [7:0] ERR_ABORTED = 8'h04;
  localparam logic [7:0] ERR_NONE = 8'h00;

  // ****************************************************************
  // Field positions and sizes.
  // ****************************************************************
  localparam int TAG_MSB = 7;
  localparam int TAG_LSB = 3;
  localparam int SEL_LBA_BIT = 6;
  localparam int SEL_DEV_BIT = 4;
  localparam int CTRL_QUEUING = 0;
  localparam int CTRL_OVERLAP = 1;
  localparam int CTRL_RELEASE = 2;
  localparam int NUM_TAGS = 32;
  localparam logic [8:0] FULL_LENGTH = 9'h100;
  localparam int ENTRY_W = 38;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_TASK_REG = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;

  // Command sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_XFER = 2'b10
  } seq_state_t;

endpackage : qdw_pkg

// ===== core/qdw_cmd_store.sv
// Per-tag store of start address, length and addressing mode.
`timescale 1ns/10ps
module qdw_cmd_store
  import qdw_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Write port.
  input wire logic wr_en,
  input wire logic [4:0] wr_tag,
  input wire logic [ENTRY_W-1:0] wr_data,
  // Read port, data one cycle later from a register.
  input wire logic [4:0] rd_tag,
  output logic [ENTRY_W-1:0] rd_data
);

  logic [ENTRY_W-1:0] mem [NUM_TAGS];

  // Entries need no reset: an entry is only read after its tag was written.
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_tag] <= wr_data;
    end
    rd_data <= mem[rd_tag];
  end

endmodule : qdw_cmd_store

// ===== core/qdw_tag_picker.sv
// Picks the lowest numbered tag that is ready for service.
`timescale 1ns/10ps
module qdw_tag_picker
  import qdw_pkg::*;
(
  // Ready bitmap.
  input wire logic [NUM_TAGS-1:0] ready,
  // Chosen tag.
  output logic any,
  output logic [4:0] tag
);

  logic [4:0] pick [NUM_TAGS+1];

  // A chain from the top down leaves the lowest set bit as the winner.
  assign pick[NUM_TAGS] = 5'h00;
  genvar i;
  generate
    for (i = 0; i < NUM_TAGS; i++) begin : g_chain
      assign pick[i] = ready[i] ? 5'(i) : pick[i+1];
    end
  endgenerate

  assign tag = pick[0];
  assign any = |ready;

endmodule : qdw_tag_picker

// ===== testbench/qdw_core_chk.sv
// Concurrent checks on the data phase and status of the queued write block.
`timescale 1ns/10ps
module qdw_core_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  // Back end.
  input wire logic sector_done,
  input wire logic xfer_error,
  input wire logic xfer_active,
  input wire logic [27:0] xfer_addr,
  input wire logic xfer_lba_mode,
  input wire logic [8:0] xfer_remaining
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A sector event that ends, or does not end, the data phase.
  sequence last_sector;
    xfer_active && sector_done && !xfer_error && xfer_remaining == 9'h001;
  endsequence
  sequence mid_sector;
    xfer_active && sector_done && !xfer_error && xfer_remaining > 9'h001;
  endsequence

  // A fresh data phase always holds between 1 and 256 sectors.
  start_count_a: assert property ($rose(xfer_active) |->
    xfer_remaining != 9'h000 && xfer_remaining <= 9'h100)
    else $error("data phase started with a bad count");
  done_count_a: assert property (last_sector |=> !xfer_active)
    else $error("data phase outlived its last sector");
  count_down_a: assert property (mid_sector |=>
    xfer_active && xfer_remaining == $past(xfer_remaining) - 9'h001)
    else $error("sector count did not step down");
  hold_count_a: assert property (xfer_active && !sector_done && !xfer_error |=>
    xfer_active && $stable(xfer_remaining) && $stable(xfer_addr))
    else $error("data phase moved without a sector event");
  lba_step_a: assert property ((mid_sector and xfer_lba_mode) |=>
    xfer_addr == $past(xfer_addr) + 28'h1)
    else $error("block address did not advance");
  chs_hold_a: assert property ((mid_sector and !xfer_lba_mode) |=> $stable(xfer_addr))
    else $error("cylinder address changed");
  error_stop_a: assert property (xfer_active && xfer_error |=> !xfer_active)
    else $error("error did not end the data phase");
  // Status is latched at the setup edge, so the state one cycle back decides it.
  data_status_a: assert property (psel && penable && !pwrite && paddr == 8'h20 &&
    $past(xfer_active) |-> (prdata[7:0] & 8'hE9) == 8'h48)
    else $error("status wrong in data phase");
endmodule : qdw_core_chk

bind qdw_core qdw_core_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .sector_done(sector_done), .xfer_error(xfer_error), .xfer_active(xfer_active),
  .xfer_addr(xfer_addr), .xfer_lba_mode(xfer_lba_mode), .xfer_remaining(xfer_remaining));

// ===== testbench/qdw_backend.sv
// Back end model that moves sectors while the data phase is open.
`timescale 1ns/10ps
module qdw_backend #(
  parameter logic [7:0] FAIL_CODE = 8'h40
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pace and fault control from the bench.
  input wire logic [5:0] gap,
  input wire logic fail,
  // Data phase at the device.
  input wire logic xfer_active,
  output logic sector_done,
  output logic xfer_error,
  output logic [7:0] xfer_error_code
);
  logic [5:0] cnt;

  // The code is only meaningful with the pulse, so it is scrambled otherwise.
  assign xfer_error_code = xfer_error ? FAIL_CODE : ~FAIL_CODE;

  // One event every gap+1 cycles of an open data phase, none outside it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h00;
      sector_done <= 1'b0;
      xfer_error <= 1'b0;
    end else begin
      sector_done <= xfer_active && cnt == gap && !fail;
      xfer_error <= xfer_active && cnt == gap && fail;
      cnt <= (!xfer_active || cnt == gap) ? 6'h00 : cnt + 6'h01;
    end
  end
endmodule : qdw_backend

// ===== testbench/tb_qdw_core.sv
// Self-checking bench for the queued DMA write command block.
`timescale 1ns/10ps
module tb_qdw_core
  import qdw_pkg::*;
;
  typedef struct packed {
    logic [2:0] ctrl;
    logic [7:0] feat, sc, a0, a1, a2, dh;
    logic [8:0] rem;
    logic [27:0] addr;
    logic [7:0] sc_go, sc_done;
  } row_t;
  row_t rows [3] = '{
    '{3'h3, 8'h01, 8'hF8, 8'h11, 8'h22, 8'h33, 8'hE5, 9'h001, 28'h5332211, 8'hF8, 8'hFB},
    '{3'h1, 8'h00, 8'h50, 8'hFF, 8'h00, 8'h80, 8'hBA, 9'h100, 28'hA8000FF, 8'h00, 8'h53},
    '{3'h0, 8'h03, 8'h50, 8'h01, 8'h02, 8'h03, 8'h40, 9'h003, 28'h0030201, 8'h00, 8'h03}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic tag_ready, sector_done, xfer_error, xfer_active, xfer_lba_mode, fail;
  logic [7:0] paddr, xfer_error_code;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] tag_ready_id, xfer_tag;
  logic [27:0] xfer_addr;
  logic [8:0] xfer_remaining;
  logic [5:0] gap;
  int n_fail, n_tests;

  qdw_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tag_ready(tag_ready), .tag_ready_id(tag_ready_id),
    .sector_done(sector_done), .xfer_error(xfer_error), .xfer_error_code(xfer_error_code),
    .xfer_active(xfer_active), .xfer_tag(xfer_tag), .xfer_addr(xfer_addr),
    .xfer_lba_mode(xfer_lba_mode), .xfer_remaining(xfer_remaining));
  qdw_backend u_back (.pclk(pclk), .presetn(presetn), .gap(gap), .fail(fail),
    .xfer_active(xfer_active), .sector_done(sector_done), .xfer_error(xfer_error),
    .xfer_error_code(xfer_error_code));

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  // The request stands until pready is seen at an edge, or for at most 20 edges; only then is it dropped.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
  endtask : apb
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : w
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      n_fail++;
    end
  endtask : chk
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q);
  endtask : rc
  // Bounded wait on the data phase flag.
  task automatic till(input logic v);
    int n;
    n = 0;
    while (xfer_active !== v && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 12000) n_fail++;
  endtask : till
  task automatic rdy(input logic [4:0] id);
    @(posedge pclk);
    tag_ready <= 1'b1;
    tag_ready_id <= id;
    @(posedge pclk);
    tag_ready <= 1'b0;
    tag_ready_id <= ~id;
  endtask : rdy
  task automatic conclude;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // The longest row needs about 8000 cycles; forty thousand leaves ample margin.
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, tag_ready, fail} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    tag_ready_id = 5'h00;
    gap = 6'h1E;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc("status reset", OFF_DEVICE_STATUS, 32'h40);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    foreach (rows[i]) begin
      w(OFF_QUEUE_CONTROL, {5'h00, rows[i].ctrl});
      w(OFF_TRANSFER_LENGTH, rows[i].feat);
      w(OFF_TAG_AND_REASON, rows[i].sc);
      w(OFF_START_ADDR_LOW, rows[i].a0);
      w(OFF_START_ADDR_MID, rows[i].a1);
      w(OFF_START_ADDR_HIGH, rows[i].a2);
      w(OFF_DEVICE_SELECT_ADDR_TOP, rows[i].dh);
      w(OFF_COMMAND_CODE, CODE_QUEUED_DMA_WRITE);
      till(1'b1);
      chk("remaining", 32'(rows[i].rem), 32'(xfer_remaining));
      chk("addr", 32'(rows[i].addr), 32'(xfer_addr));
      chk("lba", 32'(rows[i].dh[6]), 32'(xfer_lba_mode));
      rc("sc go", OFF_TAG_AND_REASON, 32'(rows[i].sc_go));
      rc("status go", OFF_DEVICE_STATUS, 32'h48);
      till(1'b0);
      rc("sc done", OFF_TAG_AND_REASON, 32'(rows[i].sc_done));
      rc("status done", OFF_DEVICE_STATUS, 32'h40);
      rc("error done", OFF_ERROR_FLAGS, 32'h0);
      apb(1'b0, OFF_DEVICE_SELECT_ADDR_TOP, 32'h0);
      chk("dev", 32'(rows[i].dh[4]), 32'(q[4]));
    end
    // Two released commands, then service in lowest-tag order.
    w(OFF_QUEUE_CONTROL, 8'h07);
    w(OFF_TAG_AND_REASON, 8'h28);
    w(OFF_COMMAND_CODE, CODE_QUEUED_DMA_WRITE);
    rc("sc rel", OFF_TAG_AND_REASON, 32'h2C);
    rc("status rel", OFF_DEVICE_STATUS, 32'h40);
    chk("no data", 32'h0, 32'(xfer_active));
    w(OFF_TAG_AND_REASON, 8'h48);
    w(OFF_COMMAND_CODE, CODE_QUEUED_DMA_WRITE);
    rc("outstanding", OFF_OUTSTANDING_TAGS, 32'h220);
    rdy(5'h09);
    rdy(5'h05);
    rc("status serv", OFF_DEVICE_STATUS, 32'h50);
    rc("sc serv", OFF_TAG_AND_REASON, 32'h4C);
    w(OFF_COMMAND_CODE, CODE_SERVICE);
    till(1'b1);
    chk("svc tag", 32'h5, 32'(xfer_tag));
    rc("status svc", OFF_DEVICE_STATUS, 32'h58);
    till(1'b0);
    rc("sc svc", OFF_TAG_AND_REASON, 32'h2B);
    rc("status next", OFF_DEVICE_STATUS, 32'h50);
    // A fault in the second serviced command drops the whole queue.
    fail <= 1'b1;
    w(OFF_COMMAND_CODE, CODE_SERVICE);
    till(1'b1);
    till(1'b0);
    rc("error code", OFF_ERROR_FLAGS, 32'h40);
    rc("status err", OFF_DEVICE_STATUS, 32'h41);
    rc("queue gone", OFF_OUTSTANDING_TAGS, 32'h0);
    rc("ready gone", OFF_READY_TAGS, 32'h0);
    fail <= 1'b0;
    w(OFF_COMMAND_CODE, CODE_SERVICE);
    rc("empty svc", OFF_ERROR_FLAGS, 32'(ERR_ABORTED));
    w(OFF_COMMAND_CODE, CODE_QUEUED_DMA_WRITE);
    rc("error cleared", OFF_ERROR_FLAGS, 32'h0);
    w(OFF_COMMAND_CODE, 8'hCA);
    rc("other code", OFF_ERROR_FLAGS, 32'(ERR_ABORTED));
    chk("other idle", 32'h0, 32'(xfer_active));
    conclude();
  end
endmodule : tb_qdw_core
